// ===== rtl/rcp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// reference clock path and pll control, apb slave
// ****************************************
module rcp_ctrl #(
    parameter int LOCK_CYCLES = rcp_pkg::LOCK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        crystal_select_pin,   // strap: crystal fitted
    output logic             pll_path_sel,         // 1: system clock from pll
    output logic             ref_div_en,           // reference input divider
    output logic [6:0]       pll_mult,             // multiplier, 12..127
    output logic             reference_copy_output_en,
    output logic [1:0]       reference_copy_drive, // 0 off, 1 low, 2 med, 3 high
    output logic [2:0]       vco_range_select,     // 0..5 valid range
    output logic [7:0]       charge_pump_current_select, // one-hot step
    output logic             pll_lock_pin
);
    rcp_cfg_if cfg ();
    logic [31:0] ctrl3_q;  // third control register
    // ****************************************
    // apb decode
    // ****************************************
    wire acc      = psel & penable;
    wire hit_c3   = (paddr == rcp_pkg::ADDR_CTRL3);
    wire hit_st   = (paddr == rcp_pkg::ADDR_STATUS);
    wire hit_icp  = (paddr == rcp_pkg::ADDR_ICP);
    wire mapped   = hit_c3 | hit_st | hit_icp;
    wire wr_c3    = acc & pwrite & hit_c3;
    // ****************************************
    // field decode
    // ****************************************
    wire [2:0] vco_f   = ctrl3_q[rcp_pkg::VCO_LSB +: 3];
    wire [2:0] icp_f   = ctrl3_q[rcp_pkg::ICP_LSB +: 3];
    wire [1:0] buf_f   = ctrl3_q[rcp_pkg::BUF_LSB +: 2];
    wire [6:0] mult_f  = ctrl3_q[rcp_pkg::MULT_LSB +: 7];
    wire       pll_en  = ctrl3_q[rcp_pkg::PLLEN_BIT];
    wire       bypass  = vco_f[2] & vco_f[1]; // codes 110, 111
    wire       use_pll = pll_en & ~bypass;
    // out-of-range multipliers clamp so the loop never sees an illegal divide
    wire [6:0] mult_c  = (mult_f < rcp_pkg::MULT_MIN) ? rcp_pkg::MULT_MIN : mult_f;
    // nominal current rises 25 ua a step; code 110 is one ua high
    wire [8:0] icp_ua  = rcp_pkg::ICP_BASE_UA + 9'(icp_f) * rcp_pkg::ICP_STEP_UA
                         + {8'h00, (icp_f == 3'b110)};
    wire [31:0] status = {28'h0000000, crystal_select_pin, cfg.locked, bypass, use_pll};
    assign cfg.pll_use = use_pll;
    assign cfg.cfg_wr  = wr_c3;
    rcp_lock_track #(.LOCK_CYCLES(LOCK_CYCLES)) u_trk (
        .pclk    (pclk),
        .presetn (presetn),
        .cfg     (cfg)
    );
    // register write; host owns source choice and divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctrl3_q <= rcp_pkg::CTRL3_RESET;
        else if (wr_c3) ctrl3_q <= pwdata & rcp_pkg::CTRL3_MASK;
    end
    // read data registered at the setup edge; zero-wait answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata  <= hit_c3 ? ctrl3_q : hit_st ? status
                     : hit_icp ? {23'h000000, icp_ua} : 32'h00000000;
        end
    end
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped; // unmapped addresses error
    // ****************************************
    // outputs from flip-flops
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_path_sel               <= 1'b0;
            ref_div_en                 <= 1'b0;
            pll_mult                   <= rcp_pkg::MULT_MIN;
            reference_copy_output_en   <= 1'b0;
            reference_copy_drive       <= 2'b00;
            vco_range_select           <= 3'b000;
            charge_pump_current_select <= 8'h01;
            pll_lock_pin               <= 1'b0;
        end else begin
            pll_path_sel               <= use_pll;
            ref_div_en                 <= ctrl3_q[rcp_pkg::DIV_BIT];
            pll_mult                   <= mult_c;
            // copy only while pll enabled and buffer not off
            reference_copy_output_en   <= pll_en & (buf_f != rcp_pkg::RCP_BUF_OFF);
            reference_copy_drive       <= pll_en ? buf_f : 2'b00;
            vco_range_select           <= bypass ? 3'b000 : vco_f;
            charge_pump_current_select <= 8'h01 << icp_f;
            pll_lock_pin               <= use_pll & cfg.locked;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/rcp_pkg.sv
// What this block does
// - pll enable picks pll or direct path
// - reference copy output only while pll enabled
// - buffer field: off, low, medium, high
// - pll multiplies reference by 12 to 127
// - vco codes 0-5 ranges, 6-7 bypass
// - charge pump codes 212 to 387 microamps
// - lock pin high once pll locked
// - lock pin low whenever pll bypassed
package rcp_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0]  ADDR_CTRL3   = 8'h00; // third control register
    localparam logic [7:0]  ADDR_STATUS  = 8'h04; // path and lock status
    localparam logic [7:0]  ADDR_ICP     = 8'h08; // decoded pump current, microamps
    // ****************************************
    // field positions in the third control register
    // ****************************************
    localparam int          BUF_LSB      = 28;    // reference copy buffer, 29:28
    localparam int          VCO_LSB      = 24;    // vco range select, 26:24
    localparam int          ICP_LSB      = 19;    // charge pump select, 21:19
    localparam int          DIV_BIT      = 15;    // reference input divider enable
    localparam int          PLLEN_BIT    = 8;     // pll enable
    localparam int          MULT_LSB     = 1;     // multiplier, 7:1
    localparam logic [31:0] CTRL3_MASK   = 32'h37b881fe; // writable bits
    localparam logic [31:0] CTRL3_RESET  = 32'h00000000; // pll off, buffer off
    // ****************************************
    // decodes and timing
    // ****************************************
    localparam logic [6:0]  MULT_MIN     = 7'h0c; // 12x
    localparam logic [6:0]  MULT_MAX     = 7'h7f; // 127x
    localparam logic [8:0]  ICP_BASE_UA  = 9'h0d4; // 212 microamps
    localparam logic [8:0]  ICP_STEP_UA  = 9'h019; // 25 microamps
    localparam int          LOCK_TIME_US = 100;   // settle time before lock flag
    localparam int          CLK_MHZ      = 20;
    localparam int          LOCK_CYCLES  = LOCK_TIME_US * CLK_MHZ;
    typedef enum logic [1:0] {
        RCP_BUF_OFF  = 2'b00,
        RCP_BUF_LOW  = 2'b01,
        RCP_BUF_MED  = 2'b10,
        RCP_BUF_HIGH = 2'b11
    } rcp_drive_t;
endpackage

// ===== rtl/rcp_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// decoded configuration passed from the register file to the lock tracker
interface rcp_cfg_if;
    logic pll_use;   // pll in use: enabled and not bypassed
    logic cfg_wr;    // one-cycle pulse on any write of the control register
    logic locked;    // lock state from tracker
    modport ctrl (output pll_use, output cfg_wr, input locked);
    modport trk  (input pll_use, input cfg_wr, output locked);
endinterface
`default_nettype wire

// ===== rtl/rcp_lock_track.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// lock tracker: models settle time of the loop
// ****************************************
module rcp_lock_track #(
    parameter int LOCK_CYCLES = rcp_pkg::LOCK_CYCLES
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    rcp_cfg_if.trk     cfg
);
    logic [15:0] cnt_q;    // cycles since loop began settling
    logic        lock_q;   // locked flag
    wire         done = (cnt_q == 16'(LOCK_CYCLES - 1));
    // any reprogramming restarts settling, since the loop must reacquire
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 16'h0000;
            lock_q <= 1'b0;
        end else if (!cfg.pll_use || cfg.cfg_wr) begin
            cnt_q  <= 16'h0000;
            lock_q <= 1'b0;
        end else if (done) begin
            lock_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 16'h0001;
        end
    end
    assign cfg.locked = lock_q;
endmodule
`default_nettype wire

// ===== testbench/rcp_ref_src.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// far side: reference source strap level
// ****
module rcp_ref_src #(parameter bit XTAL = 1'b1) (output logic crystal_select_pin);
    assign crystal_select_pin = XTAL;
endmodule
`default_nettype wire

// ===== testbench/rcp_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// pin checker for the clock path control
// ****
module rcp_ctrl_sva #(parameter int LOCK_CYCLES = 8) (
    input wire logic        pclk, presetn, psel, penable, pwrite, pll_path_sel,
    input wire logic        reference_copy_output_en, pll_lock_pin,
    input wire logic [7:0]  paddr, charge_pump_current_select,
    input wire logic [31:0] pwdata,
    input wire logic [6:0]  pll_mult,
    input wire logic [2:0]  vco_range_select,
    input wire logic [1:0]  reference_copy_drive
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire         wr = psel && penable && pwrite && paddr == 8'h00; // control word lands
    logic [31:0] w_q;                                                // last written word
    // keep the word, since the bus moves on before outputs settle
    always_ff @(posedge pclk) if (wr) w_q <= pwdata;
    path_sel_a: assert property (wr |-> ##2 pll_path_sel == (w_q[8] && w_q[26:25] != 2'b11))
        else $error("path select wrong");
    copy_out_a: assert property (wr |-> ##2 reference_copy_output_en == (w_q[8] && w_q[29:28] != 2'b00))
        else $error("copy enable wrong");
    drive_code_a: assert property (wr |-> ##2 reference_copy_drive == (w_q[8] ? w_q[29:28] : 2'b00))
        else $error("copy drive wrong");
    mult_clamp_a: assert property (wr |-> ##2 pll_mult == (w_q[7:1] < 7'h0c ? 7'h0c : w_q[7:1]))
        else $error("multiplier wrong");
    vco_code_a: assert property (wr |-> ##2 vco_range_select == (&w_q[26:25] ? 3'h0 : w_q[26:24]))
        else $error("vco range wrong");
    pump_step_a: assert property (wr |-> ##2 charge_pump_current_select == 8'h01 << w_q[21:19])
        else $error("pump select wrong");
    lock_wait_a: assert property ($rose(pll_lock_pin) |-> pll_path_sel && $past(pll_path_sel, 4))
        else $error("lock rose too early");
    lock_low_a: assert property (!pll_path_sel [*3] |-> !pll_lock_pin)
        else $error("lock high in bypass");
endmodule
bind rcp_ctrl rcp_ctrl_sva #(.LOCK_CYCLES(LOCK_CYCLES)) rcp_ctrl_sva_i (.*);
`default_nettype wire

// ===== testbench/rcp_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// bench: apb master, read notes, lock pin
// ****
module rcp_ctrl_test;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, charge_pump_current_select;
    logic [31:0] pwdata = 32'h0, prdata, w;
    logic        pready, pslverr, crystal_select_pin, pll_path_sel, ref_div_en, pll_lock_pin;
    logic        reference_copy_output_en;
    logic [6:0]  pll_mult;
    logic [1:0]  reference_copy_drive;
    logic [2:0]  vco_range_select;
    logic [65:0] notes[$], n; // {mask, expected}, error flag on top of each
    int          failures = 0, samples_checked = 0, cycles = 0;
    always #25 pclk = ~pclk;
    rcp_ref_src rcp_ref_src_i (.*);
    rcp_ctrl #(.LOCK_CYCLES(8)) rcp_ctrl_i (.*);
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one transfer, then an idle edge so no signal is set twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] m, input logic [32:0] e);
        notes.push_back({m, e});
        apb(1'b0, a, 32'h0);
    endtask
    // watcher: each read answer against the oldest note; hang limit
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (psel && penable && pready && !pwrite) begin
            n = notes.pop_front();
            chk({pslverr, prdata} & n[65:33], n[32:0], "read");
        end
        if (cycles == 1000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        w = $urandom(39804);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // every vco, pump and buffer code with random other bits
        for (int i = 0; i < 8; i++) begin
            w = $urandom;
            w[29:24] = {i[1:0], 1'b0, i[2:0]};
            w[21:19] = i[2:0];
            w[15] = 1'b1;
            w[7:1] = 7'h0c + 7'($urandom % 116);
            apb(1'b1, 8'h00, w);
            rd(8'h00, {1'b1, 32'h37b881fe}, {1'b0, w & 32'h37b881fe});
            rd(8'h08, '1, {1'b0, (i == 6) ? 32'h16b : 32'h0d4 + 32'h19 * i});
            rd(8'h04, 33'h1_ffff_fff9, {29'h0, crystal_select_pin, 2'b00, w[8] && i < 6});
            chk({32'h0, ref_div_en}, 33'h1, "divider enable");
        end
        // vco range 0 at factor 12 keeps the system clock in range
        apb(1'b1, 8'h00, 32'h0000_0118);
        for (int t = 0; t < 40 && pll_lock_pin !== 1'b1; t++) @(posedge pclk);
        chk({32'h0, pll_lock_pin}, 33'h1, "lock pin");
        rd(8'h04, 33'h1_ffff_fffd, {29'h0, crystal_select_pin, 3'b101});
        // bypass code, then a refused write to the status word
        apb(1'b1, 8'h00, 32'h0600_0118);
        apb(1'b1, 8'h04, 32'hffff_ffff);
        rd(8'h04, 33'h1_ffff_fffd, {29'h0, crystal_select_pin, 3'b000});
        chk({32'h0, pll_lock_pin}, 33'h0, "lock pin");
        chk({32'h0, ref_div_en}, 33'h0, "divider enable");
        rd(8'h00, '1, 33'h0_0600_0118);
        rd(8'h0c, '1, 33'h1_0000_0000);
        apb(1'b1, 8'h00, 32'h0000_010a); // factor below the minimum clamps
        repeat (2) @(posedge pclk);
        close_out();
    end
endmodule
`default_nettype wire
